//--- rtl/adcsc_pkg.sv
package adcsc_pkg;
   // bus and data widths
   localparam int DATA_W = 8; // register width
   localparam int ADDR_W = 4; // register address width
   localparam int RES_W = 12; // converter result width
   localparam int SEL_W = 3; // source and divider select width
   localparam int CH_W = 4; // external channel select width
   localparam int REF_W = 2; // reference select width
   localparam int ROUTE_W = 5; // one-hot analog route width
   localparam int CNT_W = 4; // converter clock counter within a phase
   localparam int DIV_W = 7; // divider counter, up to divide by 128

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0; // converter_control_main
   localparam logic [ADDR_W-1:0] OFF_CFG = 4'h1; // analog_select_config
   localparam logic [ADDR_W-1:0] OFF_RES_HI = 4'h2; // result_high_byte
   localparam logic [ADDR_W-1:0] OFF_RES_LO = 4'h3; // result_low_byte
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h4; // interrupt status
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h5; // interrupt mask

   // field positions in converter_control_main
   localparam int CTRL_START = 7; // start control bit
   localparam int CTRL_BUSY = 6; // conversion_busy_flag, read only
   localparam int CTRL_PWR = 5; // converter_power_enable
   localparam int CTRL_ALIGN = 4; // result_align_sel
   localparam int CTRL_CH_LSB = 0; // ext_channel_sel

   // field positions in analog_select_config
   localparam int CFG_SRC_LSB = 5; // analog_source_sel
   localparam int CFG_REF_LSB = 3; // ref_voltage_sel
   localparam int CFG_DIV_LSB = 0; // conv_clock_div_sel

   // interrupt status and mask layout
   localparam int IRQ_DONE_BIT = 0; // conversion complete

   // analog source codes, others route the external channel
   localparam logic [SEL_W-1:0] SRC_BANDGAP = 3'h1;
   localparam logic [SEL_W-1:0] SRC_AMP0 = 3'h2;
   localparam logic [SEL_W-1:0] SRC_AMP1 = 3'h3;
   localparam logic [SEL_W-1:0] SRC_LINE = 3'h4;
   localparam logic [REF_W-1:0] REF_SUPPLY = 2'h1; // only code using supply

   // one-hot analog routes
   localparam logic [ROUTE_W-1:0] ROUTE_EXT = 5'h01;
   localparam logic [ROUTE_W-1:0] ROUTE_BANDGAP = 5'h02;
   localparam logic [ROUTE_W-1:0] ROUTE_AMP0 = 5'h04;
   localparam logic [ROUTE_W-1:0] ROUTE_AMP1 = 5'h08;
   localparam logic [ROUTE_W-1:0] ROUTE_LINE = 5'h10;

   // converter clocks per phase
   localparam logic [CNT_W-1:0] SAMPLE_CLOCKS = 4'h4;
   localparam logic [CNT_W-1:0] CONVERT_CLOCKS = 4'hc;

   // conversion phases
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONVERT = 3'b100
   } adcsc_phase_t;
endpackage

//--- rtl/adcsc_core_if.sv
`timescale 1ns/1ps
`default_nettype none
// links the sequencer with its clock divider and result formatter
interface adcsc_core_if;
   import adcsc_pkg::*;
   logic [SEL_W-1:0] div_sel; // divide by two to this power
   logic div_run; // divider counts while high
   logic div_tick; // one pulse per converter clock
   logic [RES_W-1:0] fmt_raw; // raw result from the core
   logic fmt_align; // result_align_sel
   logic [DATA_W-1:0] fmt_high; // formatted high byte
   logic [DATA_W-1:0] fmt_low; // formatted low byte

   // sequencer side
   modport ctrl (output div_sel, output div_run, input div_tick,
      output fmt_raw, output fmt_align, input fmt_high, input fmt_low);
   // divider side
   modport div (input div_sel, input div_run, output div_tick);
   // formatter side
   modport fmt (input fmt_raw, input fmt_align, output fmt_high, output fmt_low);
endinterface
`default_nettype wire

//--- rtl/adcsc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module adcsc_clk_div #(
   parameter int CW = adcsc_pkg::DIV_W // counter width
) (
   input wire logic clock, // system clock
   input wire logic rst, // synchronous reset, active high
   adcsc_core_if.div core // select, run and tick
);
   import adcsc_pkg::*;

   // divider state
   typedef struct packed {
      logic [CW-1:0] count; // system clocks in this period
      logic tick; // converter clock pulse
   } adcsc_div_state_t;

   adcsc_div_state_t state; // registered state
   adcsc_div_state_t next_state; // next state
   logic [CW-1:0] limit; // last count of a period

   // last count is two to the select, minus one
   assign limit = CW'((1 << core.div_sel) - 1);
   assign core.div_tick = state.tick;

   // count while running, restart from zero otherwise
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (!core.div_run) begin
         next_state.count = '0; // stopped: next run starts a full period
      end else if (state.count >= limit) begin
         next_state.count = '0; // period over
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 1'b1;
      end
   end

   // register the state
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

//--- rtl/adcsc_result_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module adcsc_result_fmt (
   adcsc_core_if.fmt core // raw result in, bytes out
);
   import adcsc_pkg::*;

   // place twelve bits left or right aligned, unused bits zero
   always_comb begin
      if (core.fmt_align) begin
         core.fmt_high = {4'h0, core.fmt_raw[11:8]}; // right aligned
         core.fmt_low = core.fmt_raw[7:0];
      end else begin
         core.fmt_high = core.fmt_raw[11:4]; // left aligned
         core.fmt_low = {core.fmt_raw[3:0], 4'h0};
      end
   end
endmodule
`default_nettype wire

//--- rtl/adcsc_control.sv
`timescale 1ns/1ps
`default_nettype none

// overview
// writes land at once, reads answer a cycle later
// a written fall of start begins a conversion
// the divider ticks once per converter clock
// four sample ticks, then twelve convert ticks
// the last tick ends it: results, busy and flag
// clearing power abandons it with no result
// decoded outputs sit in flops like all others
// the tick lets the core step its bit trials
//
// register map, eight bits each
// 0x0 control: start, busy, power, align, channel
// 0x1 config: source, reference, divider
// 0x2 and 0x3 result high and low, read only
// 0x4 interrupt status, write one to clear
// 0x5 interrupt mask
//
// outputs
// source_route is one-hot: ext, bandgap, amp0, amp1, line
// ref_from_pin is always the inverse of ref_from_supply
// sample_phase and convert_phase never overlap
// irq is a level: status and mask, registered
//
// hazards for software
// a start while busy or unpowered is dropped
// a fall with the stored start low does nothing
// the mask gates only the level, not the status
// result bytes survive power down
module adcsc_control (
   input wire logic clock, // system clock, 40 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic [adcsc_pkg::ADDR_W-1:0] reg_addr, // register address
   input wire logic [adcsc_pkg::DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_write, // write strobe
   input wire logic reg_read, // read strobe
   output logic [adcsc_pkg::DATA_W-1:0] reg_rdata, // read data, next cycle
   input wire logic [adcsc_pkg::RES_W-1:0] conv_data, // result from core
   output logic core_power, // converter power
   output logic [adcsc_pkg::ROUTE_W-1:0] source_route, // one-hot route
   output logic [adcsc_pkg::CH_W-1:0] ext_channel, // external channel
   output logic ref_from_supply, // reference from supply
   output logic ref_from_pin, // reference from pin
   output logic conv_clock_tick, // converter clock pulse
   output logic sample_phase, // sampling in progress
   output logic convert_phase, // converting in progress
   output logic conversion_busy_flag, // busy flag
   output logic irq // interrupt, level
);
   import adcsc_pkg::*;

   // all registered state of the block except the divider's count and tick
   // one packed struct, so one flop process holds it all
   typedef struct packed {
      // software fields
      logic start_bit; // start control bit as last written
      logic power; // converter_power_enable
      logic align; // result_align_sel
      logic [CH_W-1:0] channel; // ext_channel_sel
      logic [SEL_W-1:0] source; // analog_source_sel
      logic [REF_W-1:0] ref_sel; // ref_voltage_sel
      logic [SEL_W-1:0] div_sel; // conv_clock_div_sel

      // sequencer
      adcsc_phase_t phase; // sequencer phase
      logic [CNT_W-1:0] ticks; // converter clocks in this phase
      logic busy; // conversion_busy_flag

      // results and interrupt
      logic [DATA_W-1:0] res_high; // result_high_byte
      logic [DATA_W-1:0] res_low; // result_low_byte
      logic irq_status; // sticky completion flag
      logic irq_mask; // completion flag enable
      logic irq; // interrupt output

      // read data and decoded outputs
      logic [DATA_W-1:0] rdata; // read data
      logic [ROUTE_W-1:0] route; // decoded analog route
      logic ref_supply; // supply reference
      logic ref_pin; // pin reference
      logic sample; // sampling phase output
      logic convert; // conversion phase output
   } adcsc_ctrl_state_t;

   adcsc_ctrl_state_t state; // registered state
   adcsc_ctrl_state_t next_state; // next state

   // this module owns the sequencer side of the link
   adcsc_core_if core (); // divider and formatter link

   // converter clock divider
   // its tick is a pulse, not a clock: one clock domain
   // the width parameter covers divide by 128
   adcsc_clk_div #(
      .CW(DIV_W)
   ) u_div (
      .clock(clock),
      .rst(rst),
      .core(core.div)
   );

   // result byte formatter
   // combinational, captured at completion
   // so the alignment bit counts at completion
   adcsc_result_fmt u_fmt (
      .core(core.fmt)
   );

   // divider runs only during a conversion
   // it stops in the cycle that ends or abandons one,
   // so no tick follows busy, even at divide by one
   // each conversion starts from a full period
   // keep the select steady while busy
   assign core.div_sel = state.div_sel;
   assign core.div_run = state.busy & next_state.busy;
   assign core.fmt_raw = conv_data;
   assign core.fmt_align = state.align;

   // outputs straight from flip-flops
   // the tick leaves the divider's own flop
   // reg_rdata is zero unless a read answer stands
   // the phase flags come from the decode below
   assign reg_rdata = state.rdata;
   assign core_power = state.power;
   assign source_route = state.route;
   assign ext_channel = state.channel;
   assign ref_from_supply = state.ref_supply;
   assign ref_from_pin = state.ref_pin;
   assign conv_clock_tick = core.div_tick;
   assign sample_phase = state.sample;
   assign convert_phase = state.convert;
   assign conversion_busy_flag = state.busy;
   assign irq = state.irq;

   // next state: bus writes, sequencer, interrupt, decode, reads
   // writes land first; the sequencer sees stored start and power
   // decode and phase outputs use the final next state
   // locals start at zero each pass, so no latch forms
   always_comb begin
      logic start_fall; // start bit brought from high to low
      logic irq_clear; // software clears completion flag
      logic done; // conversion finished this cycle
      start_fall = 1'b0;
      irq_clear = 1'b0;
      done = 1'b0;

      next_state = state;
      next_state.rdata = '0; // read data stand one cycle only

      // register writes
      // busy is read only in the control register
      // result bytes and unmapped offsets ignore writes
      // status bits clear on a written one
      // the start bit is stored even while busy
      if (reg_write) begin
         case (reg_addr)
            OFF_CTRL: begin
               // a fall implies an earlier rise, the bit resets low
               start_fall = state.start_bit & ~reg_wdata[CTRL_START];
               next_state.start_bit = reg_wdata[CTRL_START];
               next_state.power = reg_wdata[CTRL_PWR];
               next_state.align = reg_wdata[CTRL_ALIGN];
               next_state.channel = reg_wdata[CTRL_CH_LSB +: CH_W];
            end
            OFF_CFG: begin
               next_state.source = reg_wdata[CFG_SRC_LSB +: SEL_W];
               next_state.ref_sel = reg_wdata[CFG_REF_LSB +: REF_W];
               next_state.div_sel = reg_wdata[CFG_DIV_LSB +: SEL_W];
            end
            OFF_IRQ_STAT: begin
               irq_clear = reg_wdata[IRQ_DONE_BIT]; // write one to clear
            end
            OFF_IRQ_MASK: begin
               next_state.irq_mask = reg_wdata[IRQ_DONE_BIT];
            end
            default: begin
               // result bytes are read only, others unmapped
            end
         endcase
      end

      // conversion sequencer
      // at a divide of n, busy stands sixteen n plus one cycles
      // power loss in an active phase returns to idle
      // and leaves the result bytes and the flag alone
      // walk at divide by one, edge e takes the start fall:
      // e busy and sample rise; e+1 to e+16 carry the ticks
      // e+5 sample falls and convert rises
      // e+17 busy and convert fall, results and flag new
      case (state.phase)
         // idle: wait for a powered start fall
         ST_IDLE: begin
            // start only when powered, a start while busy is ignored
            if (start_fall && state.power) begin
               next_state.phase = ST_SAMPLE;
               next_state.ticks = '0;
               next_state.busy = 1'b1;
            end
         end

         // sampling: four converter clocks
         ST_SAMPLE: begin
            if (!state.power) begin
               // power removed: abandon, results untouched
               next_state.phase = ST_IDLE;
               next_state.busy = 1'b0;
            end else if (core.div_tick) begin
               if (state.ticks == SAMPLE_CLOCKS - 1'b1) begin
                  next_state.phase = ST_CONVERT;
                  next_state.ticks = '0;
               end else begin
                  next_state.ticks = state.ticks + 1'b1;
               end
            end
         end

         // converting: twelve converter clocks
         ST_CONVERT: begin
            if (!state.power) begin
               // power removed: abandon, results untouched
               next_state.phase = ST_IDLE;
               next_state.busy = 1'b0;
            end else if (core.div_tick) begin
               if (state.ticks == CONVERT_CLOCKS - 1'b1) begin
                  // finish: results, busy and flag in one cycle
                  next_state.phase = ST_IDLE;
                  next_state.busy = 1'b0;
                  next_state.res_high = core.fmt_high;
                  next_state.res_low = core.fmt_low;
                  done = 1'b1;
               end else begin
                  next_state.ticks = state.ticks + 1'b1;
               end
            end
         end

         // any other phase code
         default: begin
            // illegal code: back to idle
            next_state.phase = ST_IDLE;
            next_state.busy = 1'b0;
         end
      endcase

      // sticky completion flag, a new event beats the clear
      // a completion and a clear in one cycle leave it set
      // the level follows next status and mask, same edge
      next_state.irq_status = (state.irq_status & ~irq_clear) | done;
      next_state.irq = next_state.irq_status & next_state.irq_mask;

      // analog source decode
      // codes zero and five to seven route the external pin
      // next source is used, so a write shows one edge on
      // internal sources need the channel parked off first
      case (next_state.source)
         SRC_BANDGAP: next_state.route = ROUTE_BANDGAP;
         SRC_AMP0: next_state.route = ROUTE_AMP0;
         SRC_AMP1: next_state.route = ROUTE_AMP1;
         SRC_LINE: next_state.route = ROUTE_LINE;
         default: next_state.route = ROUTE_EXT;
      endcase

      // reference decode, every code but one uses the pin
      // the outputs are exact inverses
      // the pin function itself is set outside this block
      next_state.ref_supply = (next_state.ref_sel == REF_SUPPLY);
      next_state.ref_pin = (next_state.ref_sel != REF_SUPPLY);

      // phase outputs follow the sequencer
      // both low while idle, one high while busy
      next_state.sample = (next_state.phase == ST_SAMPLE);
      next_state.convert = (next_state.phase == ST_CONVERT);

      // register reads, shown in the following cycle
      // data reflect the state before a same-edge write
      // other cycles return zero on the read bus
      if (reg_read) begin
         case (reg_addr)
            OFF_CTRL: begin
               next_state.rdata = {state.start_bit, state.busy, state.power,
                  state.align, state.channel};
            end
            OFF_CFG: begin
               next_state.rdata = {state.source, state.ref_sel, state.div_sel};
            end
            // result bytes from the last completion
            OFF_RES_HI: begin
               next_state.rdata = state.res_high;
            end
            OFF_RES_LO: begin
               next_state.rdata = state.res_low;
            end
            OFF_IRQ_STAT: begin
               next_state.rdata = {7'h00, state.irq_status};
            end
            OFF_IRQ_MASK: begin
               next_state.rdata = {7'h00, state.irq_mask};
            end
            default: begin
               next_state.rdata = '0; // unmapped reads as zero
            end
         endcase
      end
   end

   // register the state
   // reset clears all, then sets the nonzero idle levels:
   // idle phase, external route and pin reference
   // reset only loads constants
   // a request may follow the first edge with rst low
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= '0;
         state.phase <= ST_IDLE;
         state.route <= ROUTE_EXT;
         state.ref_pin <= 1'b1;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

//--- bench/adcsc_control_props.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the converter sequencer
module adcsc_control_props
   import adcsc_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [adcsc_pkg::ADDR_W-1:0] reg_addr, // register address
   input wire logic [adcsc_pkg::DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_write, // write strobe
   input wire logic reg_read, // read strobe
   input wire logic [adcsc_pkg::DATA_W-1:0] reg_rdata, // read data
   input wire logic [adcsc_pkg::RES_W-1:0] conv_data, // core result
   input wire logic core_power, // converter power
   input wire logic [adcsc_pkg::ROUTE_W-1:0] source_route, // analog route
   input wire logic [adcsc_pkg::CH_W-1:0] ext_channel, // external channel
   input wire logic ref_from_supply, // supply reference
   input wire logic ref_from_pin, // pin reference
   input wire logic conv_clock_tick, // converter clock pulse
   input wire logic sample_phase, // sampling
   input wire logic convert_phase, // converting
   input wire logic conversion_busy_flag, // busy
   input wire logic irq // interrupt
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [4:0] tick_cnt; // converter clocks seen in this conversion
   // counts ticks while busy, restarts whenever idle
   always_ff @(posedge clock) begin
      if (rst || !conversion_busy_flag) begin
         tick_cnt <= 5'h00;
      end else begin
         tick_cnt <= tick_cnt + 5'(conv_clock_tick);
      end
   end
   route_onehot_a: assert property ($onehot(source_route))
      else $error("analog route not one-hot");
   ref_exclusive_a: assert property (ref_from_pin != ref_from_supply)
      else $error("reference source ambiguous");
   tick_in_busy_a: assert property (conv_clock_tick |-> conversion_busy_flag)
      else $error("converter clock outside conversion");
   busy_phase_a: assert property (conversion_busy_flag == (sample_phase ^ convert_phase))
      else $error("busy does not match phases");
   start_cause_a: assert property ($rose(conversion_busy_flag) |-> $past(reg_write) &&
      $past(reg_addr) == OFF_CTRL && !$past(reg_wdata[CTRL_START]) && core_power && sample_phase)
      else $error("busy rose without start fall");
   sample_len_a: assert property ($fell(sample_phase) && conversion_busy_flag |->
      tick_cnt == 5'h04) else $error("sampling not four clocks");
   conv_len_a: assert property ($fell(conversion_busy_flag) && $past(core_power) &&
      !$past(rst) |-> tick_cnt == 5'h10) else $error("conversion not sixteen clocks");
   power_off_a: assert property (!core_power |=> !conversion_busy_flag)
      else $error("busy while unpowered");
endmodule
bind adcsc_control adcsc_control_props props_i (.clock, .rst, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .conv_data, .core_power, .source_route, .ext_channel,
   .ref_from_supply, .ref_from_pin, .conv_clock_tick, .sample_phase, .convert_phase,
   .conversion_busy_flag, .irq);
`default_nettype wire

//--- bench/adcsc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog converter core: holds the level sampled while powered
module adcsc_core_model
   import adcsc_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic core_power, // converter power
   input wire logic sample_phase, // sampling window
   input wire logic convert_phase, // conversion window
   input wire logic [adcsc_pkg::RES_W-1:0] analog_level, // selected input level
   output logic [adcsc_pkg::RES_W-1:0] conv_data // result to sequencer
);
   logic [RES_W-1:0] held = 12'h000; // level captured in sampling
   logic flip = 1'b0; // toggles so stale data never looks steady
   // capture only while powered and sampling
   always_ff @(posedge clock) begin
      flip <= !flip;
      if (core_power && sample_phase) begin
         held <= analog_level;
      end
   end
   // result valid only in a powered conversion, otherwise changing junk
   assign conv_data = (core_power && convert_phase) ? held : (flip ? ~held : held ^ 12'h5a5);
endmodule
`default_nettype wire

//--- bench/adc_sequencing_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// register-level tests of the converter sequencer
module adc_sequencing_control_test;
   import adcsc_pkg::*;
   logic clock = 1'b0; // system clock
   logic rst = 1'b1; // synchronous reset
   logic [ADDR_W-1:0] reg_addr = 4'h0; // register address
   logic [DATA_W-1:0] reg_wdata = 8'h00; // write data
   logic reg_write = 1'b0; // write strobe
   logic reg_read = 1'b0; // read strobe
   logic [DATA_W-1:0] reg_rdata; // read data
   logic [RES_W-1:0] conv_data; // core result
   logic [RES_W-1:0] analog_level = 12'h000; // level on the input
   logic core_power, ref_from_supply, ref_from_pin, conv_clock_tick; // status outputs
   logic sample_phase, convert_phase, conversion_busy_flag, irq; // phase outputs
   logic [ROUTE_W-1:0] source_route; // analog route
   logic [CH_W-1:0] ext_channel; // external channel
   int miscompares = 0; // mismatches seen
   int samples_checked = 0; // comparisons made
   logic [4:0] routes [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h01, 5'h01, 5'h01};

   // 40 MHz clock
   always #12.5 clock = ~clock;

   adcsc_control dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .conv_data, .core_power, .source_route, .ext_channel, .ref_from_supply, .ref_from_pin,
      .conv_clock_tick, .sample_phase, .convert_phase, .conversion_busy_flag, .irq);
   adcsc_core_model core (.clock, .core_power, .sample_phase, .convert_phase, .analog_level,
      .conv_data);

   // counts and reports one comparison
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   // one-cycle read, data taken in the following cycle
   task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(what, {8'h00, e}, {8'h00, reg_rdata});
   endtask
   // let n edges pass, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // prints the verdict and stops
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // full conversion at one divider setting
   task automatic conv(input logic [2:0] dv, input logic al, input logic [11:0] lv,
      input logic mk);
      int n;
      int t;
      int s;
      int c;
      analog_level = lv;
      wr(OFF_IRQ_MASK, {7'h00, mk});
      wr(OFF_CFG, {5'h00, dv});
      wr(OFF_CTRL, {3'h1, al, 4'h0});
      cyc(4);
      wr(OFF_CTRL, {3'h5, al, 4'h0});
      wr(OFF_CTRL, {3'h1, al, 4'h0});
      #1;
      n = 0;
      t = 0;
      s = 0;
      c = 0;
      chk("busy at start", 16'h0001, 16'(conversion_busy_flag));
      while (conversion_busy_flag === 1'b1 && n < 5000) begin
         t += int'(conv_clock_tick);
         s += int'(sample_phase);
         c += int'(convert_phase);
         cyc(1);
         n++;
      end
      chk("busy cycles", 16'(16 * (1 << dv) + 1), 16'(n));
      chk("tick count", 16'h0010, 16'(t));
      chk("sample cycles", 16'(4 * (1 << dv) + 1), 16'(s));
      chk("convert cycles", 16'(12 * (1 << dv)), 16'(c));
      rchk("result high", OFF_RES_HI, al ? {4'h0, lv[11:8]} : lv[11:4]);
      rchk("result low", OFF_RES_LO, al ? lv[7:0] : {lv[3:0], 4'h0});
      rchk("irq status", OFF_IRQ_STAT, 8'h01);
      chk("irq level", {15'h0, mk}, {15'h0, irq});
      wr(OFF_IRQ_STAT, 8'h01);
      cyc(2);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      $display("test conversion div %0d done", dv);
   endtask

   // watchdog
   initial begin
      repeat (40000) @(posedge clock);
      miscompares++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++) begin
         rchk("reset value", 4'(a), 8'h00);
      end
      rchk("unmapped", 4'h9, 8'h00);
      wr(OFF_CTRL, 8'h5c);
      wr(OFF_RES_HI, 8'hff);
      rchk("busy read only", OFF_CTRL, 8'h1c);
      rchk("result read only", OFF_RES_HI, 8'h00);
      chk("channel", 16'h000c, 16'(ext_channel));
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         wr(OFF_CFG, {3'(i), 2'(i), 3'h0});
         cyc(1);
         chk("route", {11'h0, routes[i]}, {11'h0, source_route});
         chk("ref supply", 16'(i % 4 == 1), 16'(ref_from_supply));
         chk("ref pin", 16'(i % 4 != 1), 16'(ref_from_pin));
      end
      $display("test decode done");
      wr(OFF_CTRL, 8'h80);
      wr(OFF_CTRL, 8'h00);
      cyc(2);
      chk("unpowered start", 16'h0000, 16'(conversion_busy_flag));
      $display("test unpowered done");
      conv(3'h0, 1'b0, 12'h5a3, 1'b1);
      analog_level = 12'h123;
      wr(OFF_CTRL, 8'h20);
      wr(OFF_CTRL, 8'ha0);
      cyc(3);
      chk("rise only", 16'h0000, 16'(conversion_busy_flag));
      wr(OFF_CTRL, 8'h20);
      cyc(5);
      rchk("busy poll", OFF_CTRL, 8'h60);
      wr(OFF_CTRL, 8'h00);
      cyc(2);
      chk("abort idle", 16'h0000, 16'(conversion_busy_flag));
      chk("power off", 16'h0000, 16'(core_power));
      rchk("abort status", OFF_IRQ_STAT, 8'h00);
      rchk("kept result", OFF_RES_HI, 8'h5a);
      $display("test abort done");
      for (int d = 1; d < 8; d++) begin
         conv(3'(d), d[0], 12'h9c3 ^ 12'(d * 273), d != 3);
      end
      complete_run();
   end
endmodule
`default_nettype wire
